// ---- wdnmi_pkg.sv ----
//
// Contract
// - counter advances on 256 Hz low-speed tick
// - enabled and running straight after reset
// - 10-bit counter, interrupt on final-stage overflow
// - no clear for 3-4 s raises interrupt
// - counts in halt; interrupt releases halt
// - interrupt ignores the core enable flag
// - held off in stack-pointer mask state
// - interrupt vectors to address 0100H
// - enable bit D1: 1 counts, 0 stops
// - clear bit D0: 1 clears counter
// - clear bit always reads zero
// - upper two bits ignore writes, read zero
package wdnmi_pkg;
   // =======================================
   // register map
   localparam logic [15:0] WD_CONTROL_ADDR = 16'hFF07;
   localparam int          CLEAR_BIT       = 0;
   localparam int          ENABLE_BIT      = 1;
   localparam int          DATA_W          = 4;
   localparam logic        ENABLE_RESET    = 1'h1;
   // =======================================
   // timing
   localparam int          LS_CLOCK_HZ     = 32768;
   localparam int          TICK_HZ         = 256;
   localparam int          TICK_DIV        = LS_CLOCK_HZ / TICK_HZ;
   localparam int          CNT_W           = 10;
   localparam logic [15:0] NMI_VECTOR      = 16'h0100;
endpackage

// ---- wdnmi_tick_div.sv ----
`timescale 1ns/1ps
module wdnmi_tick_div #(
   parameter int DIV = wdnmi_pkg::TICK_DIV
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic lowSpeedCrystalClock,
   output logic      tick
);
   localparam int DW = $clog2(DIV);

   typedef struct packed {
      logic          prevLs;
      logic [DW-1:0] cnt;
      logic          tick;
   } wdnmi_div_t;

   wdnmi_div_t st;
   wdnmi_div_t next_st;

   // =======================================
   // divider: one tick per DIV rising edges of the crystal clock
   always_comb
   begin
      next_st        = st;
      next_st.prevLs = lowSpeedCrystalClock;
      next_st.tick   = 1'b0;
      if (lowSpeedCrystalClock && !st.prevLs)
      begin
         if (st.cnt == DW'(DIV - 1))
         begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
         end
         else
         begin
            next_st.cnt = st.cnt + DW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule // wdnmi_tick_div

// ---- wdnmi_timer.sv ----
`timescale 1ns/1ps
module wdnmi_timer #(
   parameter int CNT_W = wdnmi_pkg::CNT_W
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        lowSpeedCrystalClock,
   input  wire logic [15:0] ioAddr,
   input  wire logic        ioWrite,
   input  wire logic        ioRead,
   input  wire logic [3:0]  ioWdata,
   output logic      [3:0]  ioRdata,
   input  wire logic        cpuHalted,
   input  wire logic        stackPointerFirstHalfWrite,
   input  wire logic        stackPointerSecondHalfWrite,
   output logic             nmiRequest,
   output logic      [15:0] nmiVector,
   output logic             haltRelease,
   output logic      [CNT_W-1:0] wdCount
);
   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

   typedef struct packed {
      logic             wdCountEnable;
      logic [CNT_W-1:0] count;
      logic             pending;
      logic             maskState;
      logic             firstHalfSeen;
      logic             nmiRequest;
      logic             haltRelease;
      logic [15:0]      vector;
      logic [3:0]       rdata;
   } wdnmi_state_t;

   localparam wdnmi_state_t RESET_ST = '{
      wdCountEnable : wdnmi_pkg::ENABLE_RESET,
      count         : '0,
      pending       : 1'b0,
      maskState     : 1'b1,
      firstHalfSeen : 1'b0,
      nmiRequest    : 1'b0,
      haltRelease   : 1'b0,
      vector        : wdnmi_pkg::NMI_VECTOR,
      rdata         : '0
   };

   wdnmi_state_t st;
   wdnmi_state_t next_st;
   logic         tick;
   logic         regHit;
   logic         regWr;
   logic         regRd;
   logic         wdCounterClear;
   logic         overflow;

   wdnmi_tick_div #(
      .DIV (wdnmi_pkg::TICK_DIV)
   ) u_div (
      .sys_clk              (sys_clk),
      .nrst                 (nrst),
      .lowSpeedCrystalClock (lowSpeedCrystalClock),
      .tick                 (tick)
   );

   // =======================================
   // register decode
   always_comb
   begin
      regHit = (ioAddr == wdnmi_pkg::WD_CONTROL_ADDR);
      regWr  = regHit && ioWrite;
      regRd  = regHit && ioRead;
   end

   assign wdCounterClear = regWr && ioWdata[wdnmi_pkg::CLEAR_BIT];
   // clear takes priority over a tick landing in the same cycle
   assign overflow = st.wdCountEnable && tick && !wdCounterClear
                     && (st.count == CNT_MAX);

   // =======================================
   // next state
   always_comb
   begin
      next_st             = st;
      next_st.nmiRequest  = 1'b0;
      next_st.haltRelease = 1'b0;
      next_st.rdata       = '0;
      if (regWr)
      begin
         next_st.wdCountEnable = ioWdata[wdnmi_pkg::ENABLE_BIT];
      end
      if (wdCounterClear)
      begin
         next_st.count = '0;
      end
      else if (st.wdCountEnable && tick)
      begin
         // wraps to zero so later overflows raise further requests
         next_st.count = st.count + CNT_W'(1);
      end
      // only the enable bit is readable; the rest are zero
      if (regRd)
      begin
         next_st.rdata[wdnmi_pkg::ENABLE_BIT] = st.wdCountEnable;
      end
      // mask state lasts until both stack-pointer halves land in order
      if (stackPointerFirstHalfWrite)
      begin
         next_st.maskState     = 1'b1;
         next_st.firstHalfSeen = 1'b1;
      end
      else if (stackPointerSecondHalfWrite && st.firstHalfSeen)
      begin
         next_st.maskState     = 1'b0;
         next_st.firstHalfSeen = 1'b0;
      end
      // no interrupt-enable flag gates this path
      if (st.pending && !st.maskState && st.wdCountEnable)
      begin
         next_st.pending     = 1'b0;
         next_st.nmiRequest  = 1'b1;
         next_st.haltRelease = cpuHalted;
      end
      if (!st.wdCountEnable)
      begin
         next_st.pending = 1'b0;
      end
      // a new overflow wins over the clear of pending above
      if (overflow)
      begin
         next_st.pending = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st <= RESET_ST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign ioRdata     = st.rdata;
   assign nmiRequest  = st.nmiRequest;
   assign nmiVector   = st.vector;
   assign haltRelease = st.haltRelease;
   assign wdCount     = st.count;

   // =======================================
   // assertions
   property p_enable_write_one;
      @(posedge sys_clk) disable iff (!nrst)
      regWr && ioWdata[wdnmi_pkg::ENABLE_BIT] |=> st.wdCountEnable;
   endproperty
   a_enable_write_one: assert property (p_enable_write_one)
      else $error("enable bit did not set");

   property p_enable_drop_cause;
      @(posedge sys_clk) disable iff (!nrst)
      $fell(st.wdCountEnable) |-> $past(regWr) && !$past(ioWdata[wdnmi_pkg::ENABLE_BIT]);
   endproperty
   a_enable_drop_cause: assert property (p_enable_drop_cause)
      else $error("enable dropped without a write of zero");

   property p_clear;
      @(posedge sys_clk) disable iff (!nrst)
      wdCounterClear |=> st.count == '0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("counter not cleared");

   property p_count_on_tick;
      @(posedge sys_clk) disable iff (!nrst)
      (st.count != $past(st.count)) && (st.count != '0) |->
         $past(tick) && $past(st.wdCountEnable) && (st.count == $past(st.count) + CNT_W'(1));
   endproperty
   a_count_on_tick: assert property (p_count_on_tick)
      else $error("counter moved without an enabled tick");

   property p_stopped_holds;
      @(posedge sys_clk) disable iff (!nrst)
      !st.wdCountEnable && !wdCounterClear |=> $stable(st.count);
   endproperty
   a_stopped_holds: assert property (p_stopped_holds)
      else $error("disabled counter moved");

   property p_overflow_request;
      @(posedge sys_clk) disable iff (!nrst)
      overflow && !st.maskState && !stackPointerFirstHalfWrite && !regWr
         |=> st.count == '0 ##1 nmiRequest && !st.pending;
   endproperty
   a_overflow_request: assert property (p_overflow_request)
      else $error("overflow gave no request");

   property p_request_once;
      @(posedge sys_clk) disable iff (!nrst)
      nmiRequest |-> !$past(nmiRequest) && $past(st.pending);
   endproperty
   a_request_once: assert property (p_request_once)
      else $error("request without a pending overflow");

   property p_mask_holds_off;
      @(posedge sys_clk) disable iff (!nrst)
      nmiRequest |-> !$past(st.maskState);
   endproperty
   a_mask_holds_off: assert property (p_mask_holds_off)
      else $error("request during mask state");

   property p_unmasked_request;
      @(posedge sys_clk) disable iff (!nrst)
      st.pending && !st.maskState && st.wdCountEnable |=> nmiRequest;
   endproperty
   a_unmasked_request: assert property (p_unmasked_request)
      else $error("pending request not delivered");

   property p_halt_release;
      @(posedge sys_clk) disable iff (!nrst)
      haltRelease |-> nmiRequest && $past(cpuHalted);
   endproperty
   a_halt_release: assert property (p_halt_release)
      else $error("halt release without request");

   property p_read_value;
      @(posedge sys_clk) disable iff (!nrst)
      regRd |=> ioRdata == {2'h0, $past(st.wdCountEnable), 1'h0};
   endproperty
   a_read_value: assert property (p_read_value)
      else $error("bad read data");

   property p_vector;
      @(posedge sys_clk) disable iff (!nrst)
      nmiRequest |-> nmiVector == wdnmi_pkg::NMI_VECTOR;
   endproperty
   a_vector: assert property (p_vector)
      else $error("wrong interrupt vector");

   property p_cov_overflow;
      @(posedge sys_clk) disable iff (!nrst)
      overflow;
   endproperty
   c_overflow: cover property (p_cov_overflow);

   property p_cov_halt;
      @(posedge sys_clk) disable iff (!nrst)
      haltRelease;
   endproperty
   c_halt: cover property (p_cov_halt);

   property p_cov_unmask;
      @(posedge sys_clk) disable iff (!nrst)
      $fell(st.maskState);
   endproperty
   c_unmask: cover property (p_cov_unmask);
endmodule // wdnmi_timer

// ---- wdnmi_cpu_model.sv ----
`timescale 1ns/1ps
module wdnmi_cpu_model (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        nmiRequest,
   input  wire logic [15:0] nmiVector,
   input  wire logic        haltRelease,
   input  wire logic        goHalt,
   input  wire logic        spLoad,
   output logic             cpuHalted,
   output logic             stackPointerFirstHalfWrite,
   output logic             stackPointerSecondHalfWrite,
   output int               nAccept,
   output logic [15:0]      lastVector
);
   // ========================================
   // core side
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cpuHalted                   <= 1'h0;
         stackPointerFirstHalfWrite  <= 1'h0;
         stackPointerSecondHalfWrite <= 1'h0;
         nAccept                     <= 0;
         lastVector                  <= 16'h0000;
      end
      else
      begin
         // halves always written as a pair, first then second
         stackPointerFirstHalfWrite  <= spLoad;
         stackPointerSecondHalfWrite <= stackPointerFirstHalfWrite;
         // no interrupt-enable flag stands in the way
         if (nmiRequest)
         begin
            nAccept    <= nAccept + 1;
            lastVector <= nmiVector;
         end
         if (haltRelease)
            cpuHalted <= 1'h0;
         else if (goHalt)
            cpuHalted <= 1'h1;
      end
   end
endmodule // wdnmi_cpu_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   logic        sys_clk = 1'h0;
   logic        nrst = 1'h0;
   logic        lsClk = 1'h0;
   logic [15:0] ioAddr = 16'h0000;
   logic        ioWrite = 1'h0;
   logic        ioRead = 1'h0;
   logic [3:0]  ioWdata = 4'h0;
   logic [3:0]  ioRdata;
   logic        cpuHalted, spFirst, spSecond, nmiRequest, haltRelease;
   logic        goHalt = 1'h0;
   logic        spLoad = 1'h0;
   logic [15:0] nmiVector, lastVector;
   logic [3:0]  wdCount, held;
   logic        rdPend = 1'h0;
   logic [7:0]  rnd = 8'h53;
   logic [3:0]  readQ[$];
   int          nAccept, cyc = 0, nmiAt = 0, tc, n_mismatch = 0, total_checks = 0, lsPh = 0;
   localparam int PER = 16 * 128 * 4;
   localparam logic [15:0] A = wdnmi_pkg::WD_CONTROL_ADDR;
   always #10 sys_clk = ~sys_clk;
   wdnmi_timer #(.CNT_W(4)) wdnmi_timer_inst (.sys_clk(sys_clk), .nrst(nrst),
      .lowSpeedCrystalClock(lsClk), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
      .ioWdata(ioWdata), .ioRdata(ioRdata), .cpuHalted(cpuHalted),
      .stackPointerFirstHalfWrite(spFirst), .stackPointerSecondHalfWrite(spSecond),
      .nmiRequest(nmiRequest), .nmiVector(nmiVector), .haltRelease(haltRelease),
      .wdCount(wdCount));
   wdnmi_cpu_model wdnmi_cpu_model_inst (.sys_clk(sys_clk), .nrst(nrst),
      .nmiRequest(nmiRequest), .nmiVector(nmiVector), .haltRelease(haltRelease),
      .goHalt(goHalt), .spLoad(spLoad), .cpuHalted(cpuHalted),
      .stackPointerFirstHalfWrite(spFirst), .stackPointerSecondHalfWrite(spSecond),
      .nAccept(nAccept), .lastVector(lastVector));
   // ========================================
   // helpers
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [3:0] d);
      @(negedge sys_clk);
      ioAddr = a;
      ioWdata = d;
      ioWrite = 1'h1;
      @(negedge sys_clk);
      ioWrite = 1'h0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [3:0] e);
      @(negedge sys_clk);
      ioAddr = a;
      ioRead = 1'h1;
      readQ.push_back(e);
      @(negedge sys_clk);
      ioRead = 1'h0;
   endtask
   task automatic waitAcc(input int n);
      for (int i = 0; i < PER + 900 && nAccept < n; i++)
         @(negedge sys_clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ========================================
   // crystal, read monitor, timeout
   always @(negedge sys_clk)
   begin
      lsPh <= lsPh + 1;
      if (lsPh % 2 == 1)
         lsClk <= ~lsClk;
      if (rdPend)
         chk("read data", {12'h000, readQ.pop_front()}, {12'h000, ioRdata});
   end
   always @(posedge sys_clk)
   begin
      rdPend <= ioRead;
      cyc <= cyc + 1;
      if (nmiRequest === 1'h1)
         nmiAt <= cyc;
      if (cyc == 70000)
      begin
         n_mismatch++;
         results();
      end
   end
   // ========================================
   // main sequence
   initial
   begin
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      nrst = 1'h1;
      goHalt = 1'h1;
      chk("count after reset", 16'h0, {12'h0, wdCount});
      rd(A, 4'h2);
      wr(A - 16'h1, 4'h0);
      rd(A - 16'h1, 4'h0);
      wr(A, {rnd[1:0], 2'h2});
      rd(A, 4'h2);
      goHalt = 1'h0;
      $display("test register done");
      repeat (PER + 200) @(negedge sys_clk);
      chk("masked accepts", 16'h0, nAccept[15:0]);
      spLoad = 1'h1;
      @(negedge sys_clk);
      spLoad = 1'h0;
      repeat (6) @(negedge sys_clk);
      chk("pending accepts", 16'h1, nAccept[15:0]);
      chk("vector", 16'h0100, lastVector);
      chk("halt released", 16'h0, {15'h0, cpuHalted});
      $display("test mask done");
      rnd = lfsr(rnd);
      wr(A, {rnd[1:0], 2'h3});
      tc = cyc;
      waitAcc(2);
      chk("timeout window", 16'h1, {15'h0, nmiAt - tc >= PER - 512 && nmiAt - tc <= PER + 4});
      tc = nmiAt;
      waitAcc(3);
      chk("repeat period", PER[15:0], 16'(nmiAt - tc));
      $display("test timeout done");
      for (int i = 0; i < 3; i++)
      begin
         repeat (4000) @(negedge sys_clk);
         wr(A, 4'h2);
         chk("count kept", 16'h1, {15'h0, wdCount != 4'h0});
         rnd = lfsr(rnd);
         wr(A, {rnd[1:0], 2'h3});
         chk("count cleared", 16'h0, {12'h0, wdCount});
      end
      chk("no timeout", 16'h3, nAccept[15:0]);
      $display("test clearing done");
      wr(A, 4'h0);
      rd(A, 4'h0);
      held = wdCount;
      repeat (PER + 200) @(negedge sys_clk);
      chk("count stopped", {12'h0, held}, {12'h0, wdCount});
      chk("disabled accepts", 16'h3, nAccept[15:0]);
      wr(A, 4'h2);
      rd(A, 4'h2);
      $display("test disable done");
      // second reset: count must be non-zero and enable off beforehand
      repeat (1100) @(negedge sys_clk);
      chk("count running", 16'h1, {15'h0, wdCount != 4'h0});
      wr(A, 4'h0);
      nrst = 1'h0;
      repeat (2) @(negedge sys_clk);
      chk("count after second reset", 16'h0, {12'h0, wdCount});
      nrst = 1'h1;
      rd(A, 4'h2);
      repeat (3) @(negedge sys_clk);
      $display("test reset done");
      results();
   end
endmodule // tb_top
